// ---- shared/rcos_defines.svh ----
// register offsets, field positions and timing counts of the reference clock selector
`ifndef RCOS_DEFINES_SVH
`define RCOS_DEFINES_SVH

// register byte offsets
`define RCOS_OFF_CTRL_A 8'h00
`define RCOS_OFF_CTRL_B 8'h04
`define RCOS_OFF_CFG_A 8'h08
`define RCOS_OFF_CFG_B 8'h0c
`define RCOS_OFF_STATUS 8'h10

// decoded register indices
`define RCOS_IDX_CTRL_A 3'h0
`define RCOS_IDX_CTRL_B 3'h1
`define RCOS_IDX_CFG_A 3'h2
`define RCOS_IDX_CFG_B 3'h3
`define RCOS_IDX_STATUS 3'h4
`define RCOS_IDX_NONE 3'h7

// control register fields
`define RCOS_CTRL_W 7
`define RCOS_CHAN_MSB 4
`define RCOS_CHAN_LSB 0
`define RCOS_RATE_BIT 5
`define RCOS_EN_BIT 6
`define RCOS_CTRL_RST 7'h00

// config register fields
`define RCOS_CFG_W 5
`define RCOS_SRC_MSB 1
`define RCOS_SRC_LSB 0
`define RCOS_RATIO_MSB 4
`define RCOS_RATIO_LSB 2
`define RCOS_CFG_RST 5'h00

// channel count
`define RCOS_NUM_CHAN 22
`define RCOS_LAST_CHAN 5'h15

// free-running clock rates in kHz
`define RCOS_SYS_KHZ 100000
`define RCOS_T1_KHZ 1544
`define RCOS_E1_KHZ 2048
`define RCOS_HALF_T1 (`RCOS_SYS_KHZ / (2 * `RCOS_T1_KHZ))
`define RCOS_HALF_E1 (`RCOS_SYS_KHZ / (2 * `RCOS_E1_KHZ))
`define RCOS_FCNT_W 6

`endif

// ---- shared/rcos_pkg.sv ----
// types shared by the reference clock selector
`include "rcos_defines.svh"
package rcos_pkg;
  // clock source of one reference output
  typedef enum logic [1:0] {
    RCOS_SRC_RECOV = 2'b00,
    RCOS_SRC_EXT = 2'b01,
    RCOS_SRC_FREE = 2'b10,
    RCOS_SRC_RSVD = 2'b11
  } rcos_src_t;
  typedef logic [`RCOS_CTRL_W-1:0] rcos_ctrl_t;
  typedef logic [`RCOS_CFG_W-1:0] rcos_cfg_t;
endpackage

// ---- verilog/rcos_out_path.sv ----
// one reference output: source mux, rate divider and drive enable
`timescale 1ns/1ps
`default_nettype none
`include "rcos_defines.svh"
module rcos_out_path import rcos_pkg::*; (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [`RCOS_NUM_CHAN-1:0] rx_clk_i, // recovered channel clocks
  input wire logic ext_i, // external clock input
  input wire logic free_i, // free-running clock
  input wire logic [4:0] chan_i, // channel select
  input var rcos_src_t src_i, // source select
  input wire logic [2:0] ratio_i, // divide ratio minus one
  input wire logic en_i, // drive enable bit
  output logic out_o, // output level
  output logic oe_o // output enable, high drives
);
  logic sel_q;
  logic prev_q;
  logic out_q;
  logic oe_q;
  logic [2:0] cnt_q;
  logic src_d;
  logic edge_w;
  logic wrap_w;

  // source multiplexer
  always_comb begin
    unique case (src_i)
      RCOS_SRC_RECOV: src_d = (chan_i <= `RCOS_LAST_CHAN) ? rx_clk_i[chan_i] : 1'b0;
      RCOS_SRC_EXT: src_d = ext_i;
      RCOS_SRC_FREE: src_d = free_i;
      RCOS_SRC_RSVD: src_d = 1'b0;
    endcase
  end

  assign edge_w = sel_q ^ prev_q;
  assign wrap_w = (cnt_q >= ratio_i);

  // sample the selected source and track its edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sel_q <= src_d;
      prev_q <= sel_q;
    end
  end

  // drive enable; disabled output goes high impedance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= en_i;
    end
  end

  // toggle every ratio+1 source edges
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      out_q <= 1'b0;
      cnt_q <= 3'h0;
    end else if (edge_w) begin
      if (wrap_w) begin
        out_q <= ~out_q;
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign out_o = out_q;
  assign oe_o = oe_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_oe_on_enable: assert property (en_i |=> oe_o)
    else $error("output enable not raised after enable bit set");
  a_oe_off_quiet: assert property (!en_i |=> !oe_o && !out_o)
    else $error("output still driven after enable bit cleared");
  a_div_toggle: assert property (en_i && edge_w && wrap_w |=> out_o != $past(out_o))
    else $error("output missed a divider toggle");
  a_no_stray_toggle: assert property (en_i && !(edge_w && wrap_w) |=> $stable(out_o))
    else $error("output toggled without a divider wrap");
endmodule
`default_nettype wire

// ---- verilog/rcos_top.sv ----
// reference clock output selector with apb register access
//
// Overview of operation
// - output A runs from a chosen recovered channel clock of 22, external input A or a free clock.
// - the rate on output A is set by software through a divide ratio.
// - enable bit 6 of the A control register drives output A, else it floats.
// - output B runs from a chosen recovered channel clock of 22, external input B or a free clock.
// - enable bit 6 of the B control register drives output B, else it floats.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcos_defines.svh"
module rcos_top import rcos_pkg::*; (
  input wire logic CLK_SYS_I, // 100 MHz system clock
  input wire logic RST_I, // synchronous reset, active high
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb enable
  input wire logic PWRITE_I, // apb direction
  input wire logic [7:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error on unmapped address
  input wire logic [`RCOS_NUM_CHAN-1:0] RX_CLK_I, // recovered channel clocks
  input wire logic EXT_CLOCK_IN_A_I, // external clock input a
  input wire logic EXT_CLOCK_IN_B_I, // external clock input b
  output logic REF_CLOCK_OUT_A_O, // reference output a level
  output logic REF_CLOCK_OUT_A_OE_O, // reference output a enable
  output logic REF_CLOCK_OUT_B_O, // reference output b level
  output logic REF_CLOCK_OUT_B_OE_O // reference output b enable
);
  rcos_ctrl_t ctrl_q [2];
  rcos_cfg_t cfg_q [2];
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic [2:0] idx_w;
  logic wr_w;
  logic [1:0] free_q;
  logic [`RCOS_FCNT_W-1:0] fcnt_q [2];
  logic [1:0] ext_w;
  logic [1:0] out_w;
  logic [1:0] oe_w;

  // address to register index
  function automatic logic [2:0] rcos_decode(input logic [7:0] addr);
    logic [2:0] idx;
    idx = `RCOS_IDX_NONE;
    unique case (addr)
      `RCOS_OFF_CTRL_A: idx = `RCOS_IDX_CTRL_A;
      `RCOS_OFF_CTRL_B: idx = `RCOS_IDX_CTRL_B;
      `RCOS_OFF_CFG_A: idx = `RCOS_IDX_CFG_A;
      `RCOS_OFF_CFG_B: idx = `RCOS_IDX_CFG_B;
      `RCOS_OFF_STATUS: idx = `RCOS_IDX_STATUS;
      default: idx = `RCOS_IDX_NONE;
    endcase
    return idx;
  endfunction

  // half period of a free clock in system cycles
  function automatic logic [`RCOS_FCNT_W-1:0] rcos_half(input int unsigned sel);
    return (sel == 0) ? `RCOS_FCNT_W'(`RCOS_HALF_T1) : `RCOS_FCNT_W'(`RCOS_HALF_E1);
  endfunction

  // apb handshake: zero wait states
  assign idx_w = rcos_decode(PADDR_I);
  assign wr_w = PSEL_I && PENABLE_I && PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && (idx_w == `RCOS_IDX_NONE);

  // per-output control and config storage
  for (genvar o = 0; o < 2; o++) begin : g_regs
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        ctrl_q[o] <= `RCOS_CTRL_RST;
      end else if (wr_w && idx_w == (`RCOS_IDX_CTRL_A + 3'(o))) begin
        ctrl_q[o] <= PWDATA_I[`RCOS_CTRL_W-1:0];
      end
    end
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        cfg_q[o] <= `RCOS_CFG_RST;
      end else if (wr_w && idx_w == (`RCOS_IDX_CFG_A + 3'(o))) begin
        cfg_q[o] <= PWDATA_I[`RCOS_CFG_W-1:0];
      end
    end
  end

  // read word selection
  always_comb begin
    rdata_d = 32'h0;
    unique case (idx_w)
      `RCOS_IDX_CTRL_A: rdata_d = {{(32-`RCOS_CTRL_W){1'b0}}, ctrl_q[0]};
      `RCOS_IDX_CTRL_B: rdata_d = {{(32-`RCOS_CTRL_W){1'b0}}, ctrl_q[1]};
      `RCOS_IDX_CFG_A: rdata_d = {{(32-`RCOS_CFG_W){1'b0}}, cfg_q[0]};
      `RCOS_IDX_CFG_B: rdata_d = {{(32-`RCOS_CFG_W){1'b0}}, cfg_q[1]};
      `RCOS_IDX_STATUS: rdata_d = {26'h0, free_q, oe_w[1], out_w[1], oe_w[0], out_w[0]};
      default: rdata_d = 32'h0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      prdata_q <= 32'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      prdata_q <= rdata_d;
    end
  end
  assign PRDATA_O = prdata_q;

  // free-running clocks at t1 and e1 rates
  for (genvar f = 0; f < 2; f++) begin : g_free
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        fcnt_q[f] <= '0;
        free_q[f] <= 1'b0;
      end else if (fcnt_q[f] >= rcos_half(f) - `RCOS_FCNT_W'(1)) begin
        fcnt_q[f] <= '0;
        free_q[f] <= ~free_q[f];
      end else begin
        fcnt_q[f] <= fcnt_q[f] + `RCOS_FCNT_W'(1);
      end
    end
  end

  assign ext_w = {EXT_CLOCK_IN_B_I, EXT_CLOCK_IN_A_I};

  // one output path per reference output
  for (genvar o = 0; o < 2; o++) begin : g_out
    rcos_out_path u_path (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .rx_clk_i(RX_CLK_I),
      .ext_i(ext_w[o]),
      .free_i(free_q[ctrl_q[o][`RCOS_RATE_BIT]]),
      .chan_i(ctrl_q[o][`RCOS_CHAN_MSB:`RCOS_CHAN_LSB]),
      .src_i(rcos_src_t'(cfg_q[o][`RCOS_SRC_MSB:`RCOS_SRC_LSB])),
      .ratio_i(cfg_q[o][`RCOS_RATIO_MSB:`RCOS_RATIO_LSB]),
      .en_i(ctrl_q[o][`RCOS_EN_BIT]),
      .out_o(out_w[o]),
      .oe_o(oe_w[o])
    );
  end

  // pin outputs
  assign REF_CLOCK_OUT_A_O = out_w[0];
  assign REF_CLOCK_OUT_A_OE_O = oe_w[0];
  assign REF_CLOCK_OUT_B_O = out_w[1];
  assign REF_CLOCK_OUT_B_OE_O = oe_w[1];

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  // apb transfers used by the checks: writes are setup then access, the read is its setup cycle
  sequence s_wr_ctrl_a;
    PSEL_I && !PENABLE_I && PWRITE_I && idx_w == `RCOS_IDX_CTRL_A
    ##1 PSEL_I && PENABLE_I && PWRITE_I && idx_w == `RCOS_IDX_CTRL_A;
  endsequence
  sequence s_wr_cfg_b;
    PSEL_I && !PENABLE_I && PWRITE_I && idx_w == `RCOS_IDX_CFG_B
    ##1 PSEL_I && PENABLE_I && PWRITE_I && idx_w == `RCOS_IDX_CFG_B;
  endsequence
  sequence s_rd_ctrl_b;
    PSEL_I && !PENABLE_I && !PWRITE_I && idx_w == `RCOS_IDX_CTRL_B;
  endsequence

  a_ctrl_a_write: assert property (s_wr_ctrl_a |=>
    ctrl_q[0] == $past(PWDATA_I[`RCOS_CTRL_W-1:0]))
    else $error("control a did not take the written value");
  a_isolate_out_b: assert property (s_wr_ctrl_a |=> $stable(ctrl_q[1]) && $stable(cfg_q[1]))
    else $error("write to output a disturbed output b");
  a_isolate_out_a: assert property (s_wr_cfg_b |=> $stable(ctrl_q[0]) && $stable(cfg_q[0]))
    else $error("write to output b disturbed output a");
  a_read_ctrl_b: assert property (s_rd_ctrl_b |=> PRDATA_O == {25'h0, $past(ctrl_q[1])})
    else $error("read of control b returned wrong data");
  a_slverr_unmapped: assert property (PSEL_I && PENABLE_I && idx_w == `RCOS_IDX_NONE
    |-> PSLVERR_O) else $error("unmapped access not flagged");
  a_free_t1_period: assert property ($changed(free_q[0]) |->
    $past(fcnt_q[0]) == `RCOS_FCNT_W'(`RCOS_HALF_T1 - 1))
    else $error("t1 free clock toggled at wrong count");
  a_oe_a_from_bit: assert property ($rose(ctrl_q[0][`RCOS_EN_BIT]) |=>
    REF_CLOCK_OUT_A_OE_O)
    else $error("output a not driven after enable");
  a_oe_b_from_bit: assert property ($fell(ctrl_q[1][`RCOS_EN_BIT]) |=>
    !REF_CLOCK_OUT_B_OE_O)
    else $error("output b still driven after disable");
endmodule
`default_nettype wire

// ---- dv/rcos_partner.sv ----
// partner model: recovered channel clocks and external reference clocks
`timescale 1ns/1ps
`default_nettype none
module rcos_partner (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  output logic [21:0] rx_clk_o, // recovered channel clocks
  output logic ext_a_o, // external clock a
  output logic ext_b_o // external clock b
);
  logic [23:0] lvl_q;
  int cnt_q [24];
  // clock n toggles every n+2 cycles; ext a every 3, ext b every 5
  always @(posedge clk_i) begin
    for (int n = 0; n < 24; n++) begin
      if (rst_i || cnt_q[n] >= (n < 22 ? n + 1 : (n == 22 ? 2 : 4))) begin
        cnt_q[n] <= 0;
        lvl_q[n] <= rst_i ? 1'b0 : ~lvl_q[n];
      end else begin
        cnt_q[n] <= cnt_q[n] + 1;
      end
    end
  end
  assign rx_clk_o = lvl_q[21:0];
  // steady rates stand in for the line-rate clocks on the external inputs
  assign ext_a_o = lvl_q[22];
  assign ext_b_o = lvl_q[23];
endmodule
`default_nettype wire

// ---- dv/reference_clock_output_select_tb.sv ----
// self-checking bench for the reference clock selector
`timescale 1ns/1ps
`default_nettype none
`include "rcos_defines.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module reference_clock_output_select_tb;
  logic clk, rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ctrl, h;
  logic pready, pslverr, er, oa, oea, ob, oeb, ea, eb, b, rate, en, lvl;
  logic [21:0] rx;
  logic [4:0] ch;
  logic [2:0] ratio;
  logic [1:0] src, en_q;
  int checks, bad_count;
  rcos_partner PARTNER (.clk_i(clk), .rst_i(rst), .rx_clk_o(rx), .ext_a_o(ea), .ext_b_o(eb));
  rcos_top DUT (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_CLK_I(rx), .EXT_CLOCK_IN_A_I(ea),
    .EXT_CLOCK_IN_B_I(eb), .REF_CLOCK_OUT_A_O(oa), .REF_CLOCK_OUT_A_OE_O(oea),
    .REF_CLOCK_OUT_B_O(ob), .REF_CLOCK_OUT_B_OE_O(oeb));
  // clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic cur(input logic s);
    return s ? ob : oa;
  endfunction
  // half period of an output: source half period times ratio plus one
  function automatic int exp_half(input logic s, input logic [1:0] sr, input logic [4:0] c,
                                  input logic rt, input logic [2:0] r);
    int hh;
    case (sr)
      2'h0: hh = c + 2;
      2'h1: hh = s ? 5 : 3;
      default: hh = rt ? `RCOS_HALF_E1 : `RCOS_HALF_T1;
    endcase
    return hh * (r + 1);
  endfunction
  // skip a partial and a whole interval, then count one whole one
  task automatic meas(input logic s);
    logic prev;
    for (int i = 0; i < 3; i++) begin
      h = 0;
      prev = cur(s);
      while (cur(s) === prev && h < 600) begin
        @(posedge clk);
        #1;
        h++;
      end
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    en_q = 2'h0;
    void'($urandom(43));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 8'h14; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      `CHK("reset read", 32'h0, rd)
      `CHK("slverr", (a == 8'h14), er)
    end
    apb(1'b1, 8'h1c, 32'hffffffff);
    `CHK("unmapped write", 1'b1, er)
    for (int k = 0; k < 24; k++) begin
      b = $urandom % 2;
      ch = $urandom % 22;
      src = (k < 4) ? k : $urandom % 4;
      ratio = $urandom % 8;
      rate = $urandom % 2;
      en = ($urandom % 4) != 0;
      if (k == 4) begin
        ch = 5'h15;
        ratio = 3'h7;
        src = 2'h0;
        en = 1'b1;
      end
      // channel code past the last channel gives a steady level
      if (k == 5) begin
        ch = 5'h1f;
        src = 2'h0;
        en = 1'b1;
      end
      apb(1'b1, b ? `RCOS_OFF_CFG_B : `RCOS_OFF_CFG_A, {27'h0, ratio, src});
      ctrl = {25'h0, en, rate, ch};
      apb(1'b1, b ? `RCOS_OFF_CTRL_B : `RCOS_OFF_CTRL_A, ctrl);
      en_q[b] = en;
      apb(1'b0, b ? `RCOS_OFF_CTRL_B : `RCOS_OFF_CTRL_A, 32'h0);
      `CHK("ctrl readback", ctrl, rd)
      apb(1'b0, b ? `RCOS_OFF_CFG_B : `RCOS_OFF_CFG_A, 32'h0);
      `CHK("cfg readback", {27'h0, ratio, src}, rd)
      apb(1'b0, `RCOS_OFF_STATUS, 32'h0);
      `CHK("status oe", en_q, {rd[3], rd[1]})
      `CHK("oe pins", en_q, {oeb, oea})
      if (!en) begin
        `CHK("quiet out", 1'b0, cur(b))
      end else if (src == 2'h3 || (src == 2'h0 && ch > `RCOS_LAST_CHAN)) begin
        // constant source: enabled output keeps whatever level it had
        #1;
        lvl = cur(b);
        repeat (40) @(posedge clk);
        #1;
        `CHK("held out", lvl, cur(b))
      end else begin
        meas(b);
        `CHK("half period", exp_half(b, src, ch, rate, ratio), h)
      end
      `CHK("other oe", en_q[!b], b ? oea : oeb)
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
